// file: bench/bulk_link_asserts.sv
// assertions on the host-to-memory serial link
`timescale 1ns/100ps
module bulk_link_asserts (
    // clock and reset
    input wire logic MCLK,
    input wire logic ARST_N,
    // serial link
    input wire logic cs,
    input wire logic sck,
    input wire logic sdi,
    input wire logic sdo,
    input wire logic sdo_oe
);
    // ==========
    // link properties
    default clocking @(posedge MCLK); endclocking
    default disable iff (!ARST_N);
    sequence deselect_s;
        !cs ##1 !cs ##1 !cs;
    endsequence
    sequence ready_s;
        sdo_oe && sdo;
    endsequence
    chk_deselect_min:
        assert property ($fell(cs) |-> deselect_s) else $error("deselect too short");
    chk_oe_after_cs:
        assert property (sdo_oe |-> $past(cs)) else $error("status driven unselected");
    chk_oe_release:
        assert property (!cs |=> !sdo_oe) else $error("status not released");
    chk_ready_held:
        assert property (sdo_oe && sdo && cs |=> sdo || !sdo_oe) else $error("ready dropped");
    // host polls without stopping, so ready must come within the cycle length
    chk_busy_bounded:
        assert property (sdo_oe && !sdo |-> ##[1:60] ready_s) else $error("busy too long");
    chk_sck_in_frame:
        assert property ($rose(sck) |-> cs) else $error("clock outside frame");
    chk_sck_high_two:
        assert property ($rose(sck) |=> sck) else $error("clock high too short");
    chk_poll_quiet:
        assert property (sdo_oe |-> !sck) else $error("clock during poll");
endmodule

// file: bench/serial_eeprom_bulk_program_tb_top.sv
// bench: host and memory back to back, plus a rule-breaking driver on a second memory
`timescale 1ns/100ps
module serial_eeprom_bulk_program_tb_top;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic organization_select = 1'b1;
    logic cmd_valid = 1'b0;
    bulk_pkg::cmd_t cmd = bulk_pkg::CMD_PROG_EN;
    logic [15:0] cmd_data = 16'h0000;
    logic cmd_ready, done, busy, busy2;
    logic [1023:0] array, array2;
    int num_errors = 0;
    int checked = 0;
    int seed = 8;
    int cycles = 0;
    bulk_if link();
    bulk_if link2();
    always #50 mclk = ~mclk;
    bulk_host bulk_host_i (.MCLK(mclk), .ARST_N(arst_n), .ORGANIZATION_SELECT(organization_select), .CMD_VALID(cmd_valid),
        .CMD(cmd), .CMD_DATA(cmd_data), .CMD_READY(cmd_ready), .DONE(done), .LINK(link));
    bulk_mem bulk_mem_i (.MCLK(mclk), .ARST_N(arst_n), .ORGANIZATION_SELECT(organization_select), .LINK(link), .ARRAY(array),
        .BUSY(busy));
    bulk_mem bulk_mem_i2 (.MCLK(mclk), .ARST_N(arst_n), .ORGANIZATION_SELECT(1'b1), .LINK(link2),
        .ARRAY(array2), .BUSY(busy2));
    bulk_link_asserts bulk_link_asserts_i (.MCLK(mclk), .ARST_N(arst_n), .cs(link.cs), .sck(link.sck),
        .sdi(link.sdi), .sdo(link.sdo), .sdo_oe(link.sdo_oe));
    // ==========
    // helpers
    function automatic logic [1023:0] fill(input logic x16, input logic [15:0] d);
        fill = x16 ? {64{d}} : {128{d[7:0]}};
    endfunction
    task automatic check(input logic [1023:0] seen, input logic [1023:0] exp);
        checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("ERROR %0t: saw %0h wanted %0h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("errors %0d comparisons %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #10;
    endtask
    task automatic run_cmd(input bulk_pkg::cmd_t c, input logic [15:0] d, input logic [1023:0] exp);
        int busy_cnt;
        busy_cnt = 0;
        cmd = c;
        cmd_data = d;
        cmd_valid = 1'b1;
        tick(1);
        cmd_valid = 1'b0;
        check({1023'h0, cmd_ready}, 1024'h0);
        while (done !== 1'b1)
        begin
            busy_cnt += (busy === 1'b1);
            tick(1);
        end
        check({1023'h0, cmd_ready}, 1024'h1);
        check(array, exp);
        if (c == bulk_pkg::CMD_ERASE_ALL || c == bulk_pkg::CMD_WRITE_ALL)
            check({1023'h0, busy_cnt >= bulk_pkg::PROG_CYCLES}, 1024'h1);
        tick(1);
    endtask
    // mode 0 drops select in the window, 1 one rise late, 2 before the last rise
    task automatic shift(input logic [24:0] v, input int n, input int mode);
        link2.cs = 1'b1;
        for (int i = n - 1; i >= 0; i--)
        begin
            link2.sdi = v[i];
            link2.sck = 1'b0;
            tick(2);
            if (i == 0 && mode == 2)
                break;
            link2.sck = 1'b1;
            tick(2);
        end
        if (mode == 1)
        begin
            link2.sck = 1'b0;
            tick(2);
            link2.sck = 1'b1;
            tick(2);
        end
        link2.cs = 1'b0;
        link2.sdi = ~link2.sdi;
        tick(1);
        link2.sck = 1'b0;
        tick(3);
    endtask
    task automatic settle();
        for (int w = 0; w < 100 && busy2 !== 1'b0; w++)
            tick(1);
        tick(1);
    endtask
    // ==========
    // main sequence
    initial
    begin
        int r;
        link2.cs = 1'b0;
        link2.sck = 1'b0;
        link2.sdi = 1'b0;
        tick(20);
        arst_n = 1'b1;
        check(array, {1024{1'b1}});
        run_cmd(bulk_pkg::CMD_PROG_EN, 16'h0000, {1024{1'b1}});
        run_cmd(bulk_pkg::CMD_WRITE_ALL, 16'h0000, fill(1'b1, 16'h0000));
        organization_select = 1'b0;
        run_cmd(bulk_pkg::CMD_WRITE_ALL, 16'hA5C3, fill(1'b0, 16'hA5C3));
        run_cmd(bulk_pkg::CMD_PROG_DIS, 16'hFFFF, fill(1'b0, 16'hA5C3));
        run_cmd(bulk_pkg::CMD_PROG_EN, 16'h0000, fill(1'b0, 16'hA5C3));
        for (int k = 0; k < 8; k++)
        begin
            r = $random(seed);
            organization_select = r[0];
            if (r[1])
                run_cmd(bulk_pkg::CMD_ERASE_ALL, r[31:16], {1024{1'b1}});
            else
                run_cmd(bulk_pkg::CMD_WRITE_ALL, r[31:16], fill(r[0], r[31:16]));
        end
        // second memory: a driver that breaks the framing on purpose
        shift({9'h110, 16'h0F0F}, 25, 0);
        settle();
        check(array2, {1024{1'b1}});
        shift(25'h0130, 9, 0);
        shift({9'h110, 16'h0F0F}, 25, 1);
        settle();
        check(array2, {1024{1'b1}});
        shift({9'h110, 16'h0F0F}, 25, 2);
        settle();
        check(array2, {1024{1'b1}});
        shift({9'h110, 16'h0F0F}, 25, 0);
        check({1023'h0, busy2}, 1024'h1);
        shift(25'h0120, 9, 0);
        settle();
        check(array2, fill(1'b1, 16'h0F0F));
        shift(25'h0100, 9, 0);
        shift(25'h0120, 9, 0);
        settle();
        check(array2, fill(1'b1, 16'h0F0F));
        results();
    end
    // hang guard, well above the few thousand cycles the sequence needs
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            results();
        end
    end
endmodule

// file: rtl/bulk_host.sv
// host end: sends enable, disable, erase-all and write-all, polling status only after erase-all and write-all
`timescale 1ns/100ps
module bulk_host (
    // clock and reset
    input wire logic MCLK,
    input wire logic ARST_N,
    // organisation, high for 16-bit words
    input wire logic ORGANIZATION_SELECT,
    // command port
    input wire logic CMD_VALID,
    input wire bulk_pkg::cmd_t CMD,
    input wire logic [15:0] CMD_DATA,
    output logic CMD_READY,
    output logic DONE,
    // serial link
    bulk_if.host LINK
);
    typedef enum logic [2:0] {H_IDLE, H_LOW, H_HIGH, H_DESEL, H_POLL, H_WAIT} host_state_t;
    typedef struct packed {
        host_state_t st;
        logic [25:0] sh;
        logic [4:0] left;
        logic [3:0] tick;
        logic poll;
        logic cs;
        logic sck;
        logic sdi;
        logic ready;
        logic done;
    } host_s_t;
    host_s_t s_r;
    host_s_t s_nxt;
    logic [1:0] sub;
    logic [4:0] n;
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        case (CMD)
            bulk_pkg::CMD_ERASE_ALL: sub = bulk_pkg::SUB_ERASE_ALL;
            bulk_pkg::CMD_WRITE_ALL: sub = bulk_pkg::SUB_WRITE_ALL;
            bulk_pkg::CMD_PROG_EN: sub = bulk_pkg::SUB_PROG_EN;
            default: sub = bulk_pkg::SUB_PROG_DIS;
        endcase
        n = 5'(ORGANIZATION_SELECT ? bulk_pkg::HDR_X16 : bulk_pkg::HDR_X8);
        if (CMD == bulk_pkg::CMD_WRITE_ALL)
            n = n + 5'(ORGANIZATION_SELECT ? bulk_pkg::DATA_X16 : bulk_pkg::DATA_X8);
        case (s_r.st)
            H_IDLE:
            begin
                if (CMD_VALID && s_r.ready)
                begin
                    // header msb-aligned, data follows; padding bits are don't-care
                    s_nxt.sh = ORGANIZATION_SELECT ? {3'h4, sub, 4'h0, CMD_DATA, 1'b0}
                                                   : {3'h4, sub, 5'h00, CMD_DATA[7:0], 8'h00};
                    s_nxt.left = n;
                    s_nxt.poll = (CMD == bulk_pkg::CMD_ERASE_ALL) || (CMD == bulk_pkg::CMD_WRITE_ALL);
                    s_nxt.ready = 1'b0;
                    s_nxt.cs = 1'b1;
                    s_nxt.sdi = 1'b1;
                    s_nxt.tick = 4'h0;
                    s_nxt.st = H_LOW;
                end
            end
            H_LOW:
            begin
                s_nxt.tick = s_r.tick + 4'h1;
                if (int'(s_r.tick) + 1 == bulk_pkg::HALF_SCK_CYCLES)
                begin
                    s_nxt.sck = 1'b1;
                    s_nxt.tick = 4'h0;
                    s_nxt.st = H_HIGH;
                end
            end
            H_HIGH:
            begin
                s_nxt.tick = s_r.tick + 4'h1;
                if (int'(s_r.tick) + 1 == bulk_pkg::HALF_SCK_CYCLES)
                begin
                    s_nxt.tick = 4'h0;
                    s_nxt.left = s_r.left - 5'h01;
                    s_nxt.sh = {s_r.sh[24:0], 1'b0};
                    if (s_r.left == 5'h01)
                    begin
                        // drop select before any further clock rise [RULE9]
                        s_nxt.cs = 1'b0;
                        s_nxt.st = H_DESEL;
                    end
                    else
                    begin
                        s_nxt.sck = 1'b0;
                        s_nxt.sdi = s_r.sh[24];
                        s_nxt.st = H_LOW;
                    end
                end
            end
            H_DESEL:
            begin
                s_nxt.sck = 1'b0;
                s_nxt.tick = s_r.tick + 4'h1;
                // hold deselect for the minimum time [RULE1] [RULE6]
                if (int'(s_r.tick) + 1 >= bulk_pkg::MIN_DESELECT_CYCLES)
                begin
                    s_nxt.tick = 4'h0;
                    s_nxt.cs = s_r.poll;
                    s_nxt.st = s_r.poll ? H_POLL : H_WAIT;
                end
            end
            H_POLL:
            begin
                // sample status while selected [RULE4]
                if (LINK.sdo_oe && LINK.sdo)
                begin
                    s_nxt.cs = 1'b0;
                    s_nxt.st = H_WAIT;
                end
            end
            H_WAIT:
            begin
                s_nxt.tick = s_r.tick + 4'h1;
                if (int'(s_r.tick) + 1 >= bulk_pkg::MIN_DESELECT_CYCLES)
                begin
                    s_nxt.ready = 1'b1;
                    s_nxt.done = 1'b1;
                    s_nxt.st = H_IDLE;
                end
            end
            default:
                s_nxt.st = H_IDLE;
        endcase
    end
    always_ff @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            s_r <= '0;
            s_r.ready <= 1'b1;
        end
        else
            s_r <= s_nxt;
    end
    assign CMD_READY = s_r.ready;
    assign DONE = s_r.done;
    assign LINK.cs = s_r.cs;
    assign LINK.sck = s_r.sck;
    assign LINK.sdi = s_r.sdi;
endmodule

// file: rtl/bulk_if.sv
// four-wire serial link (cs, sck, sdi, sdo) between host and bulk-programmable memory
`timescale 1ns/100ps
interface bulk_if;
    logic cs;
    logic sck;
    logic sdi;
    logic sdo;
    logic sdo_oe;
    modport mem (input cs, input sck, input sdi, output sdo, output sdo_oe);
    modport host (output cs, output sck, output sdi, input sdo, input sdo_oe);
endinterface

// file: rtl/bulk_mem.sv
// memory end: shifts instructions in, runs self-timed erase-all and write-all
// Behaviour
// [RULE1] host deselects at least minimum time after erase-all
// [RULE2] proper deselect after erase-all clears whole array
// [RULE3] bulk cycle completes without further serial clocks
// [RULE4] selected during cycle, data out shows busy
// [RULE5] erase-all leaves every bit at one
// [RULE6] host deselects at least minimum time after write-all
// [RULE7] proper deselect after write-all stores word everywhere
// [RULE8] write-all correct regardless of prior contents
// [RULE9] host drops select before next clock rise
// [RULE10] select dropped outside window starts nothing
// [RULE11] start bit, opcode 00, sub-code selects operation
// [RULE12] bulk ops need prior program enable
// [RULE13] status low while busy, high when ready
// [RULE14] data word 16 or 8 bits by organisation
// [RULE15] busy cycle ignores instructions, never aborts
`timescale 1ns/100ps
module bulk_mem (
    // clock and reset
    input wire logic MCLK,
    input wire logic ARST_N,
    // organisation select, high for 16-bit words
    input wire logic ORGANIZATION_SELECT,
    // serial link
    bulk_if.mem LINK,
    // array contents, for observation
    output logic [bulk_pkg::ARRAY_BITS-1:0] ARRAY,
    output logic BUSY
);

    // ========================================================================
    // state
    typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_ARMED, ST_PROG} mem_state_t;
    typedef struct packed {
        mem_state_t st;
        logic sck_d;
        logic cs_d;
        logic [4:0] cnt;
        logic [25:0] sh;
        logic [1:0] op;
        logic [15:0] data;
        logic en;
        logic [7:0] timer;
        logic sdo;
        logic sdo_oe;
        logic [bulk_pkg::ARRAY_BITS-1:0] arr;
    } mem_s_t;
    mem_s_t s_r;
    mem_s_t s_nxt;
    logic rise;
    logic fall_cs;
    int hdr;
    int dw;

    // ========================================================================
    // decode helpers
    // header: start bit, opcode, address; one address bit more in x8
    function automatic int hdr_bits(input logic x16);
        hdr_bits = x16 ? bulk_pkg::HDR_X16 : bulk_pkg::HDR_X8;
    endfunction

    function automatic int data_bits(input logic x16);
        data_bits = x16 ? bulk_pkg::DATA_X16 : bulk_pkg::DATA_X8;
    endfunction

    // sh holds hdr-1 bits when the last header bit arrives
    function automatic logic [1:0] opcode_of(input logic [25:0] sh, input int hdr);
        opcode_of = sh[hdr-3 -: 2];
    endfunction

    function automatic logic [1:0] sub_code_of(input logic [25:0] sh, input int hdr);
        sub_code_of = sh[hdr-5 -: 2];
    endfunction

    // whole-array image: x16 word or x8 byte repeated
    function automatic logic [bulk_pkg::ARRAY_BITS-1:0] fill_image(input logic x16, input logic [15:0] d);
        fill_image = x16 ? {bulk_pkg::WORDS_X16{d}} : {bulk_pkg::WORDS_X8{d[7:0]}};
    endfunction

    // ========================================================================
    // next state
    always_comb
    begin
        s_nxt = s_r;
        hdr = hdr_bits(ORGANIZATION_SELECT);
        dw = data_bits(ORGANIZATION_SELECT);
        rise = LINK.sck & ~s_r.sck_d;
        fall_cs = s_r.cs_d & ~LINK.cs;
        s_nxt.sck_d = LINK.sck;
        s_nxt.cs_d = LINK.cs;
        case (s_r.st)
            ST_IDLE:
            begin
                s_nxt.sdo_oe = 1'b0;
                // first 1 seen on a clock rise is the start bit
                if (LINK.cs && rise && LINK.sdi)
                begin
                    s_nxt.st = ST_SHIFT;
                    s_nxt.cnt = 5'h01;
                    s_nxt.sh = 26'h000_0001;
                end
            end
            ST_SHIFT:
            begin
                if (!LINK.cs)
                    s_nxt.st = ST_IDLE;
                else if (rise)
                begin
                    s_nxt.sh = {s_r.sh[24:0], LINK.sdi};
                    s_nxt.cnt = s_r.cnt + 5'h01;
                    // [RULE11] opcode 00 then two sub-code bits
                    if (int'(s_r.cnt) + 1 == hdr)
                    begin
                        if (opcode_of(s_r.sh, hdr) != bulk_pkg::OPC_SPECIAL)
                            s_nxt.st = ST_IDLE;
                        else
                        begin
                            s_nxt.op = sub_code_of(s_r.sh, hdr);
                            if (sub_code_of(s_r.sh, hdr) == bulk_pkg::SUB_PROG_EN)
                            begin
                                s_nxt.en = 1'b1; // [RULE12]
                                s_nxt.st = ST_IDLE;
                            end
                            else if (sub_code_of(s_r.sh, hdr) == bulk_pkg::SUB_PROG_DIS)
                            begin
                                s_nxt.en = 1'b0; // [RULE12]
                                s_nxt.st = ST_IDLE;
                            end
                            else if (sub_code_of(s_r.sh, hdr) == bulk_pkg::SUB_ERASE_ALL)
                                s_nxt.st = ST_ARMED;
                        end
                    end
                    else if (int'(s_r.cnt) + 1 == hdr + dw)
                    begin
                        // [RULE14] data width follows organisation
                        s_nxt.data = ORGANIZATION_SELECT ? {s_r.sh[14:0], LINK.sdi}
                                                         : {8'h00, s_r.sh[6:0], LINK.sdi};
                        s_nxt.st = ST_ARMED;
                    end
                end
            end
            ST_ARMED:
            begin
                // window: cs must fall before the next sck rise
                if (rise)
                    s_nxt.st = ST_IDLE; // [RULE10]
                else if (fall_cs)
                begin
                    if (s_r.en) // [RULE12]
                    begin
                        s_nxt.st = ST_PROG; // [RULE2] [RULE7]
                        s_nxt.timer = 8'(bulk_pkg::PROG_CYCLES);
                    end
                    else
                        s_nxt.st = ST_IDLE;
                end
            end
            ST_PROG:
            begin
                // self-timed on MCLK; sck and sdi ignored, cs only gates status output [RULE3] [RULE15]
                s_nxt.sdo = 1'b0; // [RULE4] [RULE13]
                s_nxt.sdo_oe = LINK.cs; // [RULE4]
                if (s_r.timer == 8'h00)
                begin
                    s_nxt.st = ST_IDLE;
                    if (s_r.op == bulk_pkg::SUB_ERASE_ALL)
                        s_nxt.arr = '1; // [RULE5]
                    else
                        // direct overwrite, no prior erase needed [RULE8]
                        s_nxt.arr = fill_image(ORGANIZATION_SELECT, s_r.data); // [RULE7]
                    s_nxt.sdo = 1'b1; // [RULE13]
                end
                else
                    s_nxt.timer = s_r.timer - 8'h01;
            end
            default:
                s_nxt.st = ST_IDLE;
        endcase
        // no dummy-bit release: ready stays driven until select drops
        if (s_r.st == ST_IDLE && s_r.sdo && LINK.cs)
            s_nxt.sdo_oe = 1'b1;
        if (s_r.st == ST_IDLE && !LINK.cs)
        begin
            s_nxt.sdo = 1'b0;
            s_nxt.sdo_oe = 1'b0;
        end
    end

    // ========================================================================
    // state register
    always_ff @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            // stands in for power-up: array comes up erased, enable clear
            s_r <= '0;
            s_r.arr <= '1;
        end
        else
            s_r <= s_nxt;
    end

    // ========================================================================
    // outputs, all straight from the state register
    assign LINK.sdo = s_r.sdo;
    assign LINK.sdo_oe = s_r.sdo_oe;
    assign ARRAY = s_r.arr;
    assign BUSY = (s_r.st == ST_PROG);
endmodule

// file: rtl/bulk_pkg.sv
// shared constants and types for the bulk erase / write-all serial memory link
package bulk_pkg;
    // ========================================================================
    // organisation and instruction layout
    localparam int WORDS_X16 = 64;
    localparam int WORDS_X8 = 128;
    localparam int ARRAY_BITS = 1024;
    localparam int DATA_X16 = 16;
    localparam int DATA_X8 = 8;
    localparam int ADDR_X16 = 6;
    localparam int ADDR_X8 = 7;
    // start bit + opcode + address
    localparam int HDR_X16 = 3 + ADDR_X16;
    localparam int HDR_X8 = 3 + ADDR_X8;
    localparam logic [1:0] OPC_SPECIAL = 2'h0;
    localparam logic [1:0] SUB_ERASE_ALL = 2'h2;
    localparam logic [1:0] SUB_WRITE_ALL = 2'h1;
    localparam logic [1:0] SUB_PROG_EN = 2'h3;
    localparam logic [1:0] SUB_PROG_DIS = 2'h0;
    // ========================================================================
    // timing
    localparam int CLK_MHZ = 10;
    localparam int PROG_TIME_US = 5;
    localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
    localparam int MIN_DESELECT_NS = 250;
    localparam int MIN_DESELECT_CYCLES = (MIN_DESELECT_NS * CLK_MHZ + 999) / 1000;
    localparam int HALF_SCK_CYCLES = 2;
    localparam logic [15:0] ALL_ONES = 16'hFFFF;
    typedef enum logic [1:0] {CMD_ERASE_ALL, CMD_WRITE_ALL, CMD_PROG_EN, CMD_PROG_DIS} cmd_t;
endpackage
